/* File: stm_core.sv */
// Standard timer core with APB register access, compare, capture, PWM and single pulse.
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps

// Operation
// - Counter is compared with each comparator continuously; equality raises an interrupt.
// - A match can clear the counter and change the output pin level.
// - Three-bit select picks divided system, high or divided high, sub clock or external pin.
// - Outside single pulse mode, with the external clock chosen, each active pin edge advances the counter.
// - External clock active edge is rising or falling by selection.
// - In single pulse mode the external clock pin triggers the pulse.
// - Capture pin captures on rising, falling or both edges by two-bit field.
// - Compare output mode drives the pin high, low or toggles on match.
// - PWM appears on the same output pin as compare output.
// - Edge-aligned PWM whose duty or period is set by the comparators.
// - Separate interrupt sources for comparator A and comparator P matches.
// - High bytes are direct; low bytes move through one shared 8-bit buffer.
// - Writing the compare A low byte only loads the holding buffer.
// - Writing the compare A high byte also copies the buffer into the low byte.
// - Reading counter or compare A high byte snapshots its low byte into buffer.
// - Reading a low byte returns the holding buffer, not the live byte.
// - Ten-bit up counter clears on overflow, selected match or counter-on rising.
// - Comparator P matches the count one below P times 128, or 1023 when P is zero, so periods step by 128 counts; A matches all bits.
// - Mode field selects compare, capture, PWM or single pulse, or timer.
module stm_core (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        high_clock_en,
	input  wire logic        ext_count_clock_pin,
	input  wire logic        capture_input_pin,
	output logic             timer_output_pin,
	output logic             match_a_irq,
	output logic             match_p_irq
);

	// ==========================================================
	// Registers
	logic [7:0]                  ctrl0_q;
	logic [7:0]                  ctrl1_q;
	logic [7:0]                  subdiv_q;
	logic [stm_pkg::CNT_W-1:0]   count_q;
	logic [stm_pkg::CNT_W-1:0]   cma_q;
	logic [7:0]                  hold_q;
	logic                        sticky_a_q;
	logic                        sticky_p_q;
	logic                        on_q;
	logic [1:0]                  ck_sync_q;
	logic [1:0]                  cap_sync_q;
	logic                        ck_prev_q;
	logic                        cap_prev_q;
	logic [stm_pkg::PRESC_W-1:0] presc_q;
	logic [stm_pkg::PRESC_W-1:0] subcnt_q;
	stm_pkg::stm_sp_state_t      sp_q;
	stm_pkg::stm_cfg_t           cfg;

	logic wr_en;
	logic rd_en;
	logic tick;
	logic ck_rise;
	logic ck_fall;
	logic cap_rise;
	logic cap_fall;
	logic match_a;
	logic match_p;
	logic on_rise;
	logic capture;
	logic sp_trig;
	logic sp_mode;
	logic [stm_pkg::PRESC_W-1:0] div_sel;
	logic run;
	logic stat_wr;

	// ==========================================================
	// Configuration decode
	function automatic logic [stm_pkg::CNT_W-1:0] period_end(input logic [2:0] p);
		period_end = {p, 7'h00};
	endfunction

	assign cfg.pause                = ctrl0_q[stm_pkg::CTRL0_PAUSE_POS];
	assign cfg.count_clock_select   = ctrl0_q[stm_pkg::CTRL0_CKSEL_POS +: 3];
	assign cfg.counter_on_bit       = ctrl0_q[stm_pkg::CTRL0_ON_POS];
	assign cfg.compare_p_value      = ctrl0_q[stm_pkg::CTRL0_CMP_POS +: 3];
	assign cfg.operating_mode_field = stm_pkg::stm_mode_t'(ctrl1_q[stm_pkg::CTRL1_MODE_POS +: 2]);
	assign cfg.pin_function_select  = ctrl1_q[stm_pkg::CTRL1_PFS_POS +: 2];
	assign cfg.init_level           = ctrl1_q[stm_pkg::CTRL1_INIT_POS];
	assign cfg.polarity             = ctrl1_q[stm_pkg::CTRL1_POL_POS];
	assign cfg.duty_on_p            = ctrl1_q[stm_pkg::CTRL1_DPX_POS];
	assign cfg.clear_on_a           = ctrl1_q[stm_pkg::CTRL1_CCLR_POS];

	assign wr_en   = psel && penable && pwrite;
	// Reads act in the setup cycle, so read data and the low byte snapshot share one edge.
	assign rd_en   = psel && !penable && !pwrite;
	// Pause freezes counting and match interrupts but keeps every setting; matches still drive the output pin.
	assign run     = cfg.counter_on_bit && !cfg.pause;
	assign stat_wr = wr_en && paddr == stm_pkg::ADDR_STAT;

	// ==========================================================
	// Pin synchronisers and edge detection
	// The edge registers reset to the idle low level of the pins, so reset makes no false edge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ck_sync_q  <= 2'h0;
			cap_sync_q <= 2'h0;
			ck_prev_q  <= 1'b0;
			cap_prev_q <= 1'b0;
		end else begin
			ck_sync_q  <= {ck_sync_q[0], ext_count_clock_pin};
			cap_sync_q <= {cap_sync_q[0], capture_input_pin};
			ck_prev_q  <= ck_sync_q[1];
			cap_prev_q <= cap_sync_q[1];
		end
	end

	assign ck_rise  = ck_sync_q[1] && !ck_prev_q;
	assign ck_fall  = !ck_sync_q[1] && ck_prev_q;
	assign cap_rise = cap_sync_q[1] && !cap_prev_q;
	assign cap_fall = !cap_sync_q[1] && cap_prev_q;

	// ==========================================================
	// Count clock selection
	always_comb begin
		case (cfg.count_clock_select)
			stm_pkg::CK_SYS4: div_sel = stm_pkg::DIV_SYS4;
			stm_pkg::CK_H16:  div_sel = stm_pkg::DIV_H16;
			stm_pkg::CK_H64:  div_sel = stm_pkg::DIV_H64;
			default:          div_sel = 8'h00;
		endcase
	end

	// Internal high and sub clocks are modelled as enables so the core keeps one clock.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_q  <= 8'h00;
			subcnt_q <= 8'h00;
		end else begin
			if (cfg.count_clock_select == stm_pkg::CK_SYS4 || high_clock_en) begin
				presc_q <= (presc_q >= div_sel) ? 8'h00 : presc_q + 8'h01;
			end
			subcnt_q <= (subcnt_q >= subdiv_q) ? 8'h00 : subcnt_q + 8'h01;
		end
	end

	always_comb begin
		case (cfg.count_clock_select)
			stm_pkg::CK_SYS4: tick = (presc_q >= div_sel);
			stm_pkg::CK_H:    tick = high_clock_en;
			stm_pkg::CK_H16,
			stm_pkg::CK_H64:  tick = high_clock_en && (presc_q >= div_sel);
			stm_pkg::CK_SUBA,
			stm_pkg::CK_SUBB: tick = (subcnt_q >= subdiv_q);
			// In single pulse mode the pin is only a trigger and never clocks the counter.
			stm_pkg::CK_EXTR: tick = ck_rise && !sp_mode;
			stm_pkg::CK_EXTF: tick = ck_fall && !sp_mode;
			default:          tick = 1'b0;
		endcase
	end

	// ==========================================================
	// Counter and comparators
	// Single pulse is the fourth pin function of the PWM mode.
	assign sp_mode = cfg.operating_mode_field == stm_pkg::STM_MODE_PWM && cfg.pin_function_select == 2'h3;
	assign sp_trig = sp_mode && (cfg.count_clock_select[0] ? ck_fall : ck_rise);
	assign on_rise = cfg.counter_on_bit && !on_q;
	assign match_a = tick && (count_q == cma_q);
	assign match_p = tick && (count_q == period_end(cfg.compare_p_value) - 10'h001
		|| (cfg.compare_p_value == 3'h0 && count_q == 10'h3FF));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= 10'h000;
			on_q    <= 1'b0;
		end else begin
			on_q <= cfg.counter_on_bit;
			if (on_rise) begin
				count_q <= 10'h000;
			end else if (cfg.counter_on_bit && !cfg.pause && tick && (sp_q != stm_pkg::SP_ARMED || !sp_mode)) begin
				if ((match_a && cfg.clear_on_a) || (match_p && !cfg.clear_on_a)) begin
					count_q <= 10'h000;
				end else begin
					count_q <= count_q + 10'h001;
				end
			end
		end
	end

	// ==========================================================
	// Interrupt request pulses, with sticky flags cleared by writing ones to the status register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_a_irq <= 1'b0;
			match_p_irq <= 1'b0;
			sticky_a_q  <= 1'b0;
			sticky_p_q  <= 1'b0;
		end else begin
			match_a_irq <= match_a && run;
			match_p_irq <= match_p && run;
			// A match in the same cycle as a clear keeps the flag, so no event is lost.
			if (match_a && run) begin
				sticky_a_q <= 1'b1;
			end else if (stat_wr && pwdata[0]) begin
				sticky_a_q <= 1'b0;
			end
			if (match_p && run) begin
				sticky_p_q <= 1'b1;
			end else if (stat_wr && pwdata[1]) begin
				sticky_p_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Output pin and single pulse sequencing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_output_pin <= 1'b0;
			sp_q             <= stm_pkg::SP_IDLE;
		end else begin
			if (on_rise) begin
				timer_output_pin <= cfg.init_level;
				sp_q             <= sp_mode ? stm_pkg::SP_ARMED : stm_pkg::SP_IDLE;
			end else if (cfg.counter_on_bit) begin
				case (cfg.operating_mode_field)
					stm_pkg::STM_MODE_CMP: begin
						if (match_a) begin
							case (cfg.pin_function_select)
								2'h1:    timer_output_pin <= 1'b0;
								2'h2:    timer_output_pin <= 1'b1;
								2'h3:    timer_output_pin <= !timer_output_pin;
								default: timer_output_pin <= timer_output_pin;
							endcase
						end
					end
					stm_pkg::STM_MODE_PWM: begin
						case (cfg.pin_function_select)
							2'h0: timer_output_pin <= cfg.polarity;
							2'h1: timer_output_pin <= !cfg.polarity;
							2'h2: begin
								// Edge aligned: active from count zero until the duty match.
								if (cfg.duty_on_p ? match_p : match_a) begin
									timer_output_pin <= cfg.polarity;
								end else if (count_q == 10'h000) begin
									timer_output_pin <= !cfg.polarity;
								end
							end
							default: begin
								case (sp_q)
									stm_pkg::SP_ARMED: begin
										if (sp_trig) begin
											sp_q             <= stm_pkg::SP_RUN;
											timer_output_pin <= !cfg.polarity;
										end
									end
									stm_pkg::SP_RUN: begin
										if (match_a) begin
											sp_q             <= stm_pkg::SP_IDLE;
											timer_output_pin <= cfg.polarity;
										end
									end
									default: sp_q <= sp_q;
								endcase
							end
						endcase
					end
					default: timer_output_pin <= timer_output_pin;
				endcase
			end
		end
	end

	// ==========================================================
	// APB register file with shared low byte buffer
	assign capture = cfg.operating_mode_field == stm_pkg::STM_MODE_CAP && cfg.counter_on_bit
		&& ((cfg.pin_function_select == 2'h0 && cap_rise) || (cfg.pin_function_select == 2'h1 && cap_fall)
		|| (cfg.pin_function_select == 2'h2 && (cap_rise || cap_fall)));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl0_q  <= stm_pkg::CTRL0_RESET;
			ctrl1_q  <= stm_pkg::CTRL1_RESET;
			subdiv_q <= stm_pkg::SUBDIV_RESET;
			cma_q    <= 10'h000;
			hold_q   <= 8'h00;
		end else begin
			if (capture) begin
				cma_q <= count_q;
			end
			if (wr_en) begin
				case (paddr)
					stm_pkg::ADDR_CTRL0:  ctrl0_q  <= pwdata[7:0];
					stm_pkg::ADDR_CTRL1:  ctrl1_q  <= pwdata[7:0];
					stm_pkg::ADDR_SUBDIV: subdiv_q <= pwdata[7:0];
					stm_pkg::ADDR_CMA_LO: hold_q   <= pwdata[7:0];
					// The high byte write takes the buffer as it stood before this cycle.
					stm_pkg::ADDR_CMA_HI: cma_q    <= {pwdata[1:0], hold_q};
					default:              hold_q   <= hold_q;
				endcase
			end else if (rd_en) begin
				if (paddr == stm_pkg::ADDR_CNT_HI) begin
					hold_q <= count_q[7:0];
				end else if (paddr == stm_pkg::ADDR_CMA_HI) begin
					hold_q <= cma_q[7:0];
				end
			end
		end
	end

	// ==========================================================
	// Read data and response
	// Read data is registered in the setup cycle, so every access takes exactly two cycles.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && (paddr > stm_pkg::ADDR_SUBDIV || paddr[1:0] != 2'h0);
			if (rd_en) begin
				case (paddr)
					stm_pkg::ADDR_CTRL0:  prdata <= {24'h000000, ctrl0_q};
					stm_pkg::ADDR_CTRL1:  prdata <= {24'h000000, ctrl1_q};
					stm_pkg::ADDR_CNT_LO,
					stm_pkg::ADDR_CMA_LO: prdata <= {24'h000000, hold_q};
					stm_pkg::ADDR_CNT_HI: prdata <= {30'h0, count_q[9:8]};
					stm_pkg::ADDR_CMA_HI: prdata <= {30'h0, cma_q[9:8]};
					stm_pkg::ADDR_STAT:   prdata <= {30'h0, sticky_p_q, sticky_a_q};
					stm_pkg::ADDR_SUBDIV: prdata <= {24'h000000, subdiv_q};
					default:              prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule

/* File: stm_pkg.sv */
// Package with register map, field positions and types for the standard timer core.
package stm_pkg;

	// ==========================================================
	// Register byte addresses on APB
	localparam logic [11:0] ADDR_CTRL0  = 12'h000;
	localparam logic [11:0] ADDR_CTRL1  = 12'h004;
	localparam logic [11:0] ADDR_CNT_LO = 12'h008;
	localparam logic [11:0] ADDR_CNT_HI = 12'h00C;
	localparam logic [11:0] ADDR_CMA_LO = 12'h010;
	localparam logic [11:0] ADDR_CMA_HI = 12'h014;
	localparam logic [11:0] ADDR_STAT   = 12'h018;
	localparam logic [11:0] ADDR_SUBDIV = 12'h01C;

	// ==========================================================
	// Field positions
	localparam int CTRL0_PAUSE_POS = 7;
	localparam int CTRL0_CKSEL_POS = 4;
	localparam int CTRL0_ON_POS    = 3;
	localparam int CTRL0_CMP_POS   = 0;
	localparam int CTRL1_MODE_POS  = 6;
	localparam int CTRL1_PFS_POS   = 4;
	localparam int CTRL1_INIT_POS  = 3;
	localparam int CTRL1_POL_POS   = 2;
	localparam int CTRL1_DPX_POS   = 1;
	localparam int CTRL1_CCLR_POS  = 0;

	// ==========================================================
	// Reset values and widths
	localparam logic [7:0] CTRL0_RESET   = 8'h00;
	localparam logic [7:0] CTRL1_RESET   = 8'h00;
	localparam logic [7:0] SUBDIV_RESET  = 8'hFF;
	localparam int         CNT_W         = 10;
	localparam int         PRESC_W       = 8;

	// Prescaler terminal counts for the internal clock choices (divide by N means N-1).
	localparam logic [PRESC_W-1:0] DIV_SYS4  = 8'h03;
	localparam logic [PRESC_W-1:0] DIV_H16   = 8'h0F;
	localparam logic [PRESC_W-1:0] DIV_H64   = 8'h3F;

	// Counter clock selections.
	localparam logic [2:0] CK_SYS4  = 3'h0;
	localparam logic [2:0] CK_H     = 3'h1;
	localparam logic [2:0] CK_H16   = 3'h2;
	localparam logic [2:0] CK_H64   = 3'h3;
	localparam logic [2:0] CK_SUBA  = 3'h4;
	localparam logic [2:0] CK_SUBB  = 3'h5;
	localparam logic [2:0] CK_EXTR  = 3'h6;
	localparam logic [2:0] CK_EXTF  = 3'h7;

	typedef enum logic [1:0] {
		STM_MODE_CMP = 2'h0,
		STM_MODE_CAP = 2'h1,
		STM_MODE_PWM = 2'h2,
		STM_MODE_TMR = 2'h3
	} stm_mode_t;

	typedef struct packed {
		logic       counter_on_bit;
		logic       pause;
		logic [2:0] count_clock_select;
		logic [2:0] compare_p_value;
		stm_mode_t  operating_mode_field;
		logic [1:0] pin_function_select;
		logic       init_level;
		logic       polarity;
		logic       duty_on_p;
		logic       clear_on_a;
	} stm_cfg_t;

	typedef enum {
		SP_IDLE,
		SP_ARMED,
		SP_RUN
	} stm_sp_state_t;

endpackage

/* File: stm_core_checker.sv */
// Port checker for the timer core.
`timescale 1ns/1ps
module stm_core_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        match_a_irq,
	input wire logic        match_p_irq
);
	// ==========================================
	// Setup
	logic setup;
	logic bad;
	assign setup = psel && !penable;
	assign bad   = (paddr > 12'h01C) || (paddr[1:0] != 2'h0);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ==========================================
	// Assertions
	property p_acc_rdy; psel && penable |-> pready; endproperty
	a_acc_rdy: assert property (p_acc_rdy) else $error("access without pready");
	property p_rdy_one; pready |=> !pready; endproperty
	a_rdy_one: assert property (p_rdy_one) else $error("pready too long");
	property p_err_rdy; pslverr |-> pready; endproperty
	a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
	property p_err_bad; setup && bad |=> pslverr; endproperty
	a_err_bad: assert property (p_err_bad) else $error("bad address accepted");
	property p_err_ok; setup && !bad |=> !pslverr; endproperty
	a_err_ok: assert property (p_err_ok) else $error("good address refused");
	// Read data from any register must hold its value until the next read setup cycle.
	property p_rd_hold; !(setup && !pwrite) |=> $stable(prdata); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_a_pulse; match_a_irq |=> !match_a_irq; endproperty
	a_a_pulse: assert property (p_a_pulse) else $error("match a irq too long");
	property p_p_pulse; match_p_irq |=> !match_p_irq; endproperty
	a_p_pulse: assert property (p_p_pulse) else $error("match p irq too long");
	c_read: cover property (setup && !pwrite ##1 pready);
	c_err: cover property (pslverr);
	c_irq_a: cover property (match_a_irq);
	c_irq_p: cover property (match_p_irq);
endmodule

bind stm_core stm_core_checker u_stm_core_checker (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .match_a_irq(match_a_irq), .match_p_irq(match_p_irq)
);

/* File: stm_pins_model.sv */
// Model of the clock ticks and pins around the timer core.
`timescale 1ns/1ps
module stm_pins_model (
	input  wire logic pclk,
	input  wire logic presetn,
	output logic      high_clock_en,
	output logic      ext_count_clock_pin,
	output logic      capture_input_pin
);
	// ==========================================
	// Pins
	// Pins are wired straight to the core, as if already routed.
	initial begin
		ext_count_clock_pin = 1'b0;
		capture_input_pin = 1'b0;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			high_clock_en <= 1'b0;
		end else begin
			high_clock_en <= !high_clock_en;
		end
	end
	// Levels last four cycles so the synchroniser cannot miss them.
	task automatic ext_pulses(input int n);
		repeat (n) begin
			ext_count_clock_pin <= 1'b1;
			repeat (4) @(posedge pclk);
			ext_count_clock_pin <= 1'b0;
			repeat (4) @(posedge pclk);
		end
	endtask
	task automatic cap_toggle;
		capture_input_pin <= !capture_input_pin;
		repeat (4) @(posedge pclk);
	endtask
endmodule

/* File: tb_top.sv */
// Self-checking bench for the timer core.
`timescale 1ns/1ps
module tb_top;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        high_clock_en;
	logic        ext_count_clock_pin;
	logic        capture_input_pin;
	logic        timer_output_pin;
	logic        match_a_irq;
	logic        match_p_irq;
	logic [31:0] r;
	logic        e;
	int          mismatches;
	int          compares;
	int          cyc;
	int          na;
	int          np;
	int          hi;

	stm_core u_stm_core (
		.pclk                (pclk),
		.presetn             (presetn),
		.psel                (psel),
		.penable             (penable),
		.pwrite              (pwrite),
		.paddr               (paddr),
		.pwdata              (pwdata),
		.prdata              (prdata),
		.pready              (pready),
		.pslverr             (pslverr),
		.high_clock_en       (high_clock_en),
		.ext_count_clock_pin (ext_count_clock_pin),
		.capture_input_pin   (capture_input_pin),
		.timer_output_pin    (timer_output_pin),
		.match_a_irq         (match_a_irq),
		.match_p_irq         (match_p_irq)
	);
	stm_pins_model u_stm_pins_model (
		.pclk                (pclk),
		.presetn             (presetn),
		.high_clock_en       (high_clock_en),
		.ext_count_clock_pin (ext_count_clock_pin),
		.capture_input_pin   (capture_input_pin)
	);

	// ==========================================
	// Clock, watchdog and event counts
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		na += (match_a_irq === 1'b1);
		np += (match_p_irq === 1'b1);
		if (cyc == 20000) begin
			mismatches++;
			finish_test;
		end
	end

	// ==========================================
	// Tasks
	task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
		compares++;
		if (g !== x) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", s, x, g);
		end
	endtask
	// One idle cycle between transfers keeps psel from being driven twice at one edge.
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for pready.
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 8'h00);
		chk($sformatf("reg %h", a), x, r);
	endtask
	task automatic finish_test;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ==========================================
	// Tests
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(stm_pkg::ADDR_CTRL0, 32'h0);
		rd(stm_pkg::ADDR_CTRL1, 32'h0);
		rd(stm_pkg::ADDR_SUBDIV, 32'hFF);
		rd(12'h020, 32'h0);
		chk("slverr", 32'h1, {31'h0, e});
		$display("test regs done");
		// Low then high on writes, high then low on reads.
		wr(stm_pkg::ADDR_CMA_LO, 8'h5A);
		rd(stm_pkg::ADDR_CMA_HI, 32'h0);
		rd(stm_pkg::ADDR_CMA_LO, 32'h0);
		wr(stm_pkg::ADDR_CMA_LO, 8'h5A);
		wr(stm_pkg::ADDR_CMA_HI, 8'h02);
		rd(stm_pkg::ADDR_CMA_LO, 32'h5A);
		wr(stm_pkg::ADDR_CMA_LO, 8'h33);
		rd(stm_pkg::ADDR_CMA_HI, 32'h2);
		rd(stm_pkg::ADDR_CMA_LO, 32'h5A);
		$display("test byte buffer done");
		wr(stm_pkg::ADDR_CTRL1, 8'hC0);
		wr(stm_pkg::ADDR_CTRL0, 8'h68);
		u_stm_pins_model.ext_pulses(5);
		rd(stm_pkg::ADDR_CNT_HI, 32'h0);
		rd(stm_pkg::ADDR_CNT_LO, 32'h5);
		wr(stm_pkg::ADDR_CTRL0, 8'h70);
		wr(stm_pkg::ADDR_CTRL0, 8'h78);
		u_stm_pins_model.ext_pulses(3);
		rd(stm_pkg::ADDR_CNT_HI, 32'h0);
		rd(stm_pkg::ADDR_CNT_LO, 32'h3);
		$display("test event count done");
		wr(stm_pkg::ADDR_CTRL0, 8'h60);
		wr(stm_pkg::ADDR_CTRL1, 8'h31);
		wr(stm_pkg::ADDR_CMA_LO, 8'h03);
		wr(stm_pkg::ADDR_CMA_HI, 8'h00);
		wr(stm_pkg::ADDR_CTRL0, 8'h68);
		chk("pin", 32'h0, {31'h0, timer_output_pin});
		na = 0;
		// The match is taken on the tick that finds the counter at the compare value.
		u_stm_pins_model.ext_pulses(4);
		chk("pin", 32'h1, {31'h0, timer_output_pin});
		chk("irq a", 32'h1, na);
		rd(stm_pkg::ADDR_STAT, 32'h1);
		wr(stm_pkg::ADDR_STAT, 8'h03);
		rd(stm_pkg::ADDR_STAT, 32'h0);
		wr(stm_pkg::ADDR_CTRL1, 8'h11);
		u_stm_pins_model.ext_pulses(4);
		chk("pin low", 32'h0, {31'h0, timer_output_pin});
		wr(stm_pkg::ADDR_CTRL1, 8'h21);
		u_stm_pins_model.ext_pulses(4);
		chk("pin high", 32'h1, {31'h0, timer_output_pin});
		$display("test compare output done");
		wr(stm_pkg::ADDR_CTRL1, 8'hC0);
		wr(stm_pkg::ADDR_CTRL0, 8'h01);
		na = 0;
		np = 0;
		wr(stm_pkg::ADDR_CTRL0, 8'h09);
		repeat (1100) @(posedge pclk);
		chk("irq p", 32'h2, np);
		chk("irq a", 32'h3, na);
		rd(stm_pkg::ADDR_CNT_HI, 32'h0);
		$display("test period done");
		for (int i = 0; i < 3; i++) begin
			wr(stm_pkg::ADDR_CTRL0, 8'h60);
			wr(stm_pkg::ADDR_CTRL1, {2'h1, i[1:0], 4'h0});
			wr(stm_pkg::ADDR_CTRL0, 8'h68);
			u_stm_pins_model.ext_pulses(i + 2);
			u_stm_pins_model.cap_toggle();
			rd(stm_pkg::ADDR_CMA_HI, 32'h0);
			rd(stm_pkg::ADDR_CMA_LO, i + 2);
		end
		$display("test capture done");
		wr(stm_pkg::ADDR_CTRL0, 8'h01);
		wr(stm_pkg::ADDR_CMA_LO, 8'h40);
		wr(stm_pkg::ADDR_CMA_HI, 8'h00);
		wr(stm_pkg::ADDR_CTRL1, 8'hA0);
		wr(stm_pkg::ADDR_CTRL0, 8'h09);
		repeat (20) @(posedge pclk);
		hi = 0;
		repeat (1024) begin
			@(posedge pclk);
			hi += (timer_output_pin === 1'b1);
		end
		chk("pwm half duty", 32'h1, (hi > 500 && hi < 524));
		wr(stm_pkg::ADDR_CTRL1, 8'h90);
		@(posedge pclk);
		chk("pwm active", 32'h1, {31'h0, timer_output_pin});
		wr(stm_pkg::ADDR_CTRL1, 8'h80);
		@(posedge pclk);
		chk("pwm inactive", 32'h0, {31'h0, timer_output_pin});
		$display("test pwm done");
		wr(stm_pkg::ADDR_CTRL0, 8'h60);
		wr(stm_pkg::ADDR_CTRL1, 8'hB0);
		wr(stm_pkg::ADDR_CMA_LO, 8'h05);
		wr(stm_pkg::ADDR_CMA_HI, 8'h00);
		wr(stm_pkg::ADDR_CTRL0, 8'h08);
		@(posedge pclk);
		chk("pulse armed", 32'h0, {31'h0, timer_output_pin});
		u_stm_pins_model.ext_pulses(1);
		chk("pulse started", 32'h1, {31'h0, timer_output_pin});
		repeat (40) @(posedge pclk);
		chk("pulse ended", 32'h0, {31'h0, timer_output_pin});
		$display("test single pulse done");
		finish_test;
	end
endmodule
